// ---- spd_post_divider.sv ----
// Post-dividers B and C of the first synthesizer with frame pulse shaping
`include "spd_regs.svh"

module spd_post_divider (
    // Clock, reset and enable
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  clockEnable,
    // Register access
    input  wire spd_pkg::spd_reg_req_t regReq,
    output logic [7:0]                 readData,
    // Sibling divider outputs
    input  wire logic                  relatedClockA,
    input  wire logic                  relatedClockD,
    // Output clocks
    output logic                       clockOutB,
    output logic                       clockOutC
);
    import spd_pkg::*;

    spd_state_t state;
    spd_state_t next_state;

    // ****************************************
    // Mode and field decoding
    // ****************************************
    function automatic logic isFramePulse(input logic [23:0] cfg);
        return cfg[`SPD_SHAPE_MSB:`SPD_SHAPE_LSB] == `SPD_SHAPE_PULSE;
    endfunction

    function automatic logic [15:0] lastPeriod(input logic [23:0] cfg);
        logic [15:0] space;
        space = cfg[`SPD_SPACE_MSB:`SPD_SPACE_LSB];
        return (space <= 16'h0001) ? 16'h0000 : space - 16'h0001;
    endfunction

    // Own code selects nothing, so a reserved select stays quiet
    function automatic logic pickRelated(input logic [1:0] sel,
                                         input logic [1:0] ownCode,
                                         input logic       clkA,
                                         input logic       clkB,
                                         input logic       clkC,
                                         input logic       clkD);
        logic rel;
        case (sel)
            2'h0: rel = clkA;
            2'h1: rel = clkB;
            2'h2: rel = clkC;
            2'h3: rel = clkD;
            default: rel = 1'b0;
        endcase
        if (sel == ownCode) begin
            rel = 1'b0;
        end
        return rel;
    endfunction

    // ****************************************
    // Frame pulse step
    // ****************************************
    function automatic spd_chan_t frameStep(input logic [23:0] cfg,
                                            input spd_chan_t   st,
                                            input logic        rel,
                                            input logic        act);
        spd_chan_t   nx;
        logic        rise;
        logic        fall;
        logic [15:0] last;
        logic        wrap;
        nx = st;
        nx.relPrev = rel;
        nx.count = 24'h000000;
        rise = rel & ~st.relPrev;
        fall = ~rel & st.relPrev;
        last = lastPeriod(cfg);
        wrap = (st.relCount >= last);
        if (!act) begin
            nx.relCount = 16'h0000;
            nx.pulse = 1'b0;
        end else begin
            if (rise) begin
                nx.relCount = wrap ? 16'h0000 : st.relCount + 16'h0001;
            end
            if (cfg[`SPD_STYLE_BIT]) begin
                if (rise) begin
                    nx.pulse = wrap;
                end
            end else if (fall) begin
                nx.pulse = (st.relCount == last);
            end
        end
        nx.out = nx.pulse ^ cfg[`SPD_POLAR_BIT];
        return nx;
    endfunction

    // ****************************************
    // Divided clock step
    // ****************************************
    function automatic spd_chan_t clockStep(input logic [23:0] cfg,
                                            input spd_chan_t   st,
                                            input logic        rel);
        spd_chan_t   nx;
        logic [23:0] half;
        nx = st;
        nx.relPrev = rel;
        nx.relCount = 16'h0000;
        nx.pulse = 1'b0;
        half = {1'b0, cfg[23:1]};
        if (cfg < 24'h000002) begin
            nx.count = 24'h000000;
            nx.out = 1'b0;
        end else begin
            nx.count = (st.count >= cfg - 24'h000001) ? 24'h000000
                     : st.count + 24'h000001;
            nx.out = (nx.count < half);
        end
        return nx;
    endfunction

    // ****************************************
    // One channel step
    // ****************************************
    function automatic spd_chan_t stepChannel(input logic [23:0] cfg,
                                              input spd_chan_t   st,
                                              input logic        rel,
                                              input logic        act);
        spd_chan_t nx;
        if (isFramePulse(cfg)) begin
            nx = frameStep(cfg, st, rel, act);
        end else begin
            nx = clockStep(cfg, st, rel);
        end
        return nx;
    endfunction

    // ****************************************
    // Register read decode
    // ****************************************
    function automatic logic [7:0] readByte(input logic [7:0]  addr,
                                            input logic [23:0] divB,
                                            input logic [23:0] divC);
        logic [7:0] res;
        case (addr)
            `SPD_DIV_B_HIGH: res = divB[23:16];
            `SPD_DIV_B_MID:  res = divB[15:8];
            `SPD_DIV_B_LOW:  res = divB[7:0];
            `SPD_DIV_C_HIGH: res = divC[23:16];
            `SPD_DIV_C_MID:  res = divC[15:8];
            `SPD_DIV_C_LOW:  res = divC[7:0];
            default: res = 8'h00;
        endcase
        return res;
    endfunction

    // ****************************************
    // Byte write into a 24-bit register
    // ****************************************
    function automatic logic [23:0] writeByte(input logic [23:0] cur,
                                              input logic [1:0]  lane,
                                              input logic [7:0]  data);
        logic [23:0] res;
        res = cur;
        case (lane)
            2'h2: res[23:16] = data;
            2'h1: res[15:8] = data;
            2'h0: res[7:0] = data;
            default: res = cur;
        endcase
        return res;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic relB;
        logic relC;
        logic actB;
        logic actC;
        relB = 1'b0;
        relC = 1'b0;
        actB = 1'b0;
        actC = 1'b0;
        next_state = state;
        if (clockEnable) begin
            relB = pickRelated(state.divB[`SPD_SEL_MSB:`SPD_SEL_LSB], 2'h1, relatedClockA,
                               state.chanB.out, state.chanC.out, relatedClockD);
            relC = pickRelated(state.divC[`SPD_SEL_MSB:`SPD_SEL_LSB], 2'h2, relatedClockA,
                               state.chanB.out, state.chanC.out, relatedClockD);
            actB = (state.divB[`SPD_SEL_MSB:`SPD_SEL_LSB] != 2'h1);
            actC = (state.divC[`SPD_SEL_MSB:`SPD_SEL_LSB] != 2'h2);
            next_state.chanB = stepChannel(state.divB, state.chanB, relB, actB);
            next_state.chanC = stepChannel(state.divC, state.chanC, relC, actC);
            if (regReq.write) begin
                case (regReq.addr)
                    `SPD_DIV_B_HIGH: next_state.divB = writeByte(state.divB, 2'h2, regReq.writeData);
                    `SPD_DIV_B_MID:  next_state.divB = writeByte(state.divB, 2'h1, regReq.writeData);
                    `SPD_DIV_B_LOW:  next_state.divB = writeByte(state.divB, 2'h0, regReq.writeData);
                    `SPD_DIV_C_HIGH: next_state.divC = writeByte(state.divC, 2'h2, regReq.writeData);
                    `SPD_DIV_C_MID:  next_state.divC = writeByte(state.divC, 2'h1, regReq.writeData);
                    `SPD_DIV_C_LOW:  next_state.divC = writeByte(state.divC, 2'h0, regReq.writeData);
                    default: next_state.divB = state.divB;
                endcase
            end
            next_state.readData = readByte(regReq.addr, state.divB, state.divC);
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.divB <= `SPD_DIV_RESET;
            state.divC <= `SPD_DIV_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign readData = state.readData;
    assign clockOutB = state.chanB.out;
    assign clockOutC = state.chanC.out;

endmodule

// ---- spd_regs.svh ----
// Register offsets, field positions and reset values of the synthesizer post-dividers
// Summary of operation
// - Shape field all ones selects frame pulse
// - Otherwise whole register divides the VCO clock
// - Pulse width is one related-clock period
// - Channel B select: 00 A, 10 C, 11 D
// - Polarity bit: 0 normal, 1 inverted
// - Style bit: 0 mid-pulse boundary, 1 edge boundary
// - Low sixteen bits count periods between pulses
// - Channel C normal output is VCO over value
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// ****************************************
// Byte offsets, high byte first
// ****************************************
`define SPD_DIV_B_HIGH   8'h9B
`define SPD_DIV_B_MID    8'h9C
`define SPD_DIV_B_LOW    8'h9D
`define SPD_DIV_C_HIGH   8'h9E
`define SPD_DIV_C_MID    8'h9F
`define SPD_DIV_C_LOW    8'hA0

// ****************************************
// Fields and reset values
// ****************************************
`define SPD_SHAPE_MSB    23
`define SPD_SHAPE_LSB    20
`define SPD_SHAPE_PULSE  4'hF
`define SPD_STYLE_BIT    19
`define SPD_POLAR_BIT    18
`define SPD_SEL_MSB      17
`define SPD_SEL_LSB      16
`define SPD_SPACE_MSB    15
`define SPD_SPACE_LSB    0
`define SPD_DIV_RESET    24'h000000

`endif

// ---- spd_pkg.sv ----
// Types shared by the synthesizer post-divider block
package spd_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] writeData;
        logic       write;
    } spd_reg_req_t;

    typedef struct packed {
        logic [23:0] count;
        logic [15:0] relCount;
        logic        relPrev;
        logic        pulse;
        logic        out;
    } spd_chan_t;

    typedef struct packed {
        logic [23:0] divB;
        logic [23:0] divC;
        spd_chan_t   chanB;
        spd_chan_t   chanC;
        logic [7:0]  readData;
    } spd_state_t;

endpackage

// ---- spd_sibling_model.sv ----
// Sibling divider that drives one related clock
module spd_sibling_model #(parameter int HALF = 4) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Related clock
    output logic      clkOut
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always @(posedge clk or posedge reset)
        if (reset) {cnt, clkOut} <= '0;
        else begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) clkOut <= ~clkOut;
        end
endmodule

// ---- spd_post_divider_monitor.sv ----
// Port checks for the post-divider block
module spd_post_divider_monitor (
    // Clock and control
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  clockEnable,
    // Register access
    input wire spd_pkg::spd_reg_req_t regReq,
    input wire logic [7:0]            readData,
    // Clocks
    input wire logic                  relatedClockA,
    input wire logic                  relatedClockD,
    input wire logic                  clockOutB,
    input wire logic                  clockOutC
);
    timeunit 1ns;
    timeprecision 1ns;
    import spd_pkg::*;
    logic [7:0]  sh [6];
    logic [23:0] sb, sc;
    logic        mapped;
    assign mapped = regReq.addr inside {[8'h9B:8'hA0]};
    assign sb = {sh[0], sh[1], sh[2]};
    assign sc = {sh[3], sh[4], sh[5]};
    always_ff @(posedge clk or posedge reset)
        if (reset) sh <= '{default: 8'h00};
        else if (clockEnable && regReq.write && mapped)
            sh[3'(regReq.addr - 8'h9B)] <= regReq.writeData;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    unmapped_read_a: assert property (clockEnable && !mapped |=> readData == 8'h00)
        else $error("unmapped read");
    write_readback_a: assert property (clockEnable && regReq.write && mapped
        ##1 clockEnable && $stable(regReq.addr) |=> readData == $past(regReq.writeData, 2))
        else $error("readback");
    frozen_outputs_a: assert property (!clockEnable |=> $stable({readData, clockOutB, clockOutC}))
        else $error("not frozen");
    reset_low_a: assert property ($past(reset) |-> {readData, clockOutB, clockOutC} == 10'h000)
        else $error("reset outputs");
    reserved_sel_b_a: assert property (sb[23:20] == 4'hF && sb[17:16] == 2'b01
        && $past(sb[23:16], 3) == sb[23:16] |-> clockOutB == sb[18]) else $error("select B");
    reserved_sel_c_a: assert property (sc[23:20] == 4'hF && sc[17:16] == 2'b10
        && $past(sc[23:16], 3) == sc[23:16] |-> clockOutC == sc[18]) else $error("select C");
    divide_four_a: assert property (sb == 24'h4 && $past(sb, 6) == 24'h4 && $rose(clockOutB)
        |-> {$past(clockOutB, 4), $past(clockOutB, 3), $past(clockOutB, 2),
        $past(clockOutB)} == 4'b1100) else $error("divide B");
    divide_five_a: assert property (sc == 24'h5 && $past(sc, 7) == 24'h5 && $rose(clockOutC)
        |-> {$past(clockOutC, 5), $past(clockOutC, 4), $past(clockOutC, 3),
        $past(clockOutC, 2), $past(clockOutC)} == 5'b11000) else $error("divide C");
endmodule

// ---- synth_post_divider_frame_pulse_tb_top.sv ----
// Testbench for the post-divider block
module synth_post_divider_frame_pulse_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spd_pkg::*;
    logic         clk = 0, reset = 1, clockEnable = 1, ra;
    logic         relatedClockA, relatedClockD, clockOutB, clockOutC;
    spd_reg_req_t regReq = '0;
    logic [7:0]   readData;
    int           failures = 0, tests_run = 0, w, p;
    logic [23:0]  cfg [5] = '{24'hF80003, 24'hFC0003, 24'hF00003, 24'hFB0002, 24'hFA0002};
    int           ew [5] = '{8, 16, 8, 12, 6};
    int           ep [5] = '{24, 24, 24, 24, 12};
    logic         era [3] = '{1'b1, 1'b1, 1'b0};
    always #20 clk = ~clk;
    spd_post_divider spd_post_divider_i (.clk, .reset, .clockEnable, .regReq, .readData,
        .relatedClockA, .relatedClockD, .clockOutB, .clockOutC);
    spd_sibling_model #(.HALF(4)) spd_sibling_model_i (.clk, .reset, .clkOut(relatedClockA));
    spd_sibling_model #(.HALF(6)) spd_sibling_model_i2 (.clk, .reset, .clkOut(relatedClockD));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        for (int k = 0; k < 3; k++) begin
            regReq <= '{8'(a + k), v[23 - 8 * k -: 8], 1'b1};
            @(posedge clk);
        end
        regReq.write <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic cur(input bit c);
        return c ? clockOutC : clockOutB;
    endfunction
    task automatic meas(input bit c);
        repeat (40) @(negedge clk);
        for (int i = 0; i < 300 && cur(c) !== 1'b0; i++) @(negedge clk);
        for (int i = 0; i < 300 && cur(c) !== 1'b1; i++) @(negedge clk);
        ra = relatedClockA;
        for (w = 0; w < 300 && cur(c) === 1'b1; w++) @(negedge clk);
        for (p = w; p < 600 && cur(c) === 1'b0; p++) @(negedge clk);
        @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (int a = 8'h9B; a <= 8'hA1; a++) begin
            regReq <= '{8'(a), 8'h00, 1'b0};
            @(posedge clk);
            @(negedge clk);
            chk("readData", readData, 0);
            @(posedge clk);
        end
        $display("test reset values done");
        wr(8'h9B, 24'h000004);
        wr(8'h9E, 24'h000005);
        meas(0);
        chk("width B", w, 2);
        chk("period B", p, 4);
        meas(1);
        chk("width C", w, 2);
        chk("period C", p, 5);
        $display("test divide done");
        wr(8'h9E, 24'h000006);
        for (int i = 0; i < 5; i++) begin
            wr(8'h9B, cfg[i]);
            meas(0);
            chk("pulse width", w, ew[i]);
            chk("pulse spacing", p, ep[i]);
            if (i < 3) chk("boundary", ra, era[i]);
        end
        $display("test frame pulse done");
        clockEnable <= 1'b0;
        repeat (6) @(posedge clk);
        clockEnable <= 1'b1;
        wr(8'h9B, 24'hF50003);
        wr(8'h9E, 24'hF20001);
        repeat (4) @(negedge clk);
        chk("reserved B", clockOutB, 1);
        chk("reserved C", clockOutC, 0);
        $display("test reserved select done");
        print_verdict();
    end
    initial begin
        #(40 * 20000);
        failures++;
        print_verdict();
    end
endmodule
bind spd_post_divider spd_post_divider_monitor spd_post_divider_monitor_i (.clk, .reset,
    .clockEnable, .regReq, .readData, .relatedClockA, .relatedClockD, .clockOutB, .clockOutC);
